/* File: design/teo_pkg.sv */
// Constants, field layout and state types of the timed event output unit.
// Assumes one 125 MHz clock and an AXI4-Lite master on the register side.
package teo_pkg;

   localparam int ADDR_W = 12;
   localparam int Q_DEPTH = 16;
   localparam int Q_PTR_W = 4;

   // Register byte offsets
   localparam logic [11:0] OFF_TCTRL = 12'h048;
   localparam logic [11:0] OFF_EVCTRL = 12'h04C;
   localparam logic [11:0] OFF_STEPF = 12'h050;
   localparam logic [11:0] OFF_STEPW = 12'h054;
   localparam logic [11:0] OFF_SHNS = 12'h084;
   localparam logic [11:0] OFF_SHSEC = 12'h088;
   localparam logic [11:0] OFF_LIVENS = 12'h08C;
   localparam logic [11:0] OFF_LIVESEC = 12'h090;
   localparam logic [11:0] OFF_CMPL = 12'h0D0;
   localparam logic [11:0] OFF_CMPH = 12'h0D4;
   localparam logic [11:0] OFF_SCMPL = 12'h0D8;
   localparam logic [11:0] OFF_SCMPH = 12'h0DC;
   localparam logic [11:0] OFF_HP0L = 12'h0F0;
   localparam logic [11:0] OFF_HP0H = 12'h0F4;
   localparam logic [11:0] OFF_HP1L = 12'h0F8;
   localparam logic [11:0] OFF_HP1H = 12'h0FC;
   localparam logic [11:0] OFF_STATUS = 12'h100;
   localparam logic [11:0] OFF_RATE = 12'h204;

   // Field positions
   localparam int TC_LOAD = 0;
   localparam int EV_QTRIG = 2;
   localparam int EV_STRIG = 3;
   localparam int EV_P0EN = 4;
   localparam int EV_P1EN = 5;
   localparam int EV_P0OE = 6;
   localparam int EV_P1OE = 7;
   localparam int EV_P0INIT = 8;
   localparam int EV_P0HOLD = 9;
   localparam int EV_P1INIT = 10;
   localparam int EV_P1HOLD = 11;
   localparam int EV_DUTY = 12;
   localparam int STEP_FRAC_BITS = 40;
   localparam int HP_FRAC_BITS = 16;

   // Trigger state codes
   localparam logic [1:0] ST_LOW = 2'b00;
   localparam logic [1:0] ST_HIGH = 2'b01;

   localparam logic [31:0] NS_PER_SEC = 32'h3B9A_CA00;
   localparam logic [31:0] CLK_RATE_HZ = 32'h0773_5940;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [1:0] st;
      logic [19:0] sec;
      logic [31:0] ns;
   } teo_cmp_t;

   typedef struct packed {
      logic awHave;
      logic [11:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic [31:0] evCtrl;
      logic [31:0] stepFrac;
      logic [31:0] stepWhole;
      logic [31:0] shNs;
      logic [31:0] shSec;
      logic [63:0] stepLive;
      logic [31:0] timeSec;
      logic [31:0] timeNs;
      logic [39:0] timeSub;
      logic [31:0] cmpLow;
      logic [31:0] sCmpLow;
      teo_cmp_t [Q_DEPTH-1:0] queue;
      logic [3:0] qRd;
      logic [3:0] qWr;
      logic [4:0] qCnt;
      teo_cmp_t single;
      logic sArmed;
      logic trigQ;
      logic trigS;
      logic [31:0] hp0Low;
      logic [31:0] hp1Low;
      logic [63:0] hp0;
      logic [63:0] hp1;
      logic [64:0] rem0;
      logic [64:0] rem1;
      logic run0;
      logic run1;
      logic lvl0;
      logic lvl1;
      logic phase0;
   } teo_state_t;

endpackage

/* File: design/teo_timed_event_outputs.sv */
// Time-of-day counter with compare triggers and square wave outputs.
// Assumes an AXI4-Lite master on the same clock and pins sampled outside.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module teo_timed_event_outputs import teo_pkg::*; #(
   parameter logic [31:0] CLK_HZ = CLK_RATE_HZ
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [11:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [11:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic queuedCompareOutput,
   output logic singleCompareOutput,
   output logic primarySquareOutput,
   output logic secondarySquareOutput
);

   teo_state_t s;
   teo_state_t n;
   logic wrDo;
   logic [11:0] wa;
   logic [31:0] wd;
   logic [32:0] wrOld;
   logic [32:0] rdVal;
   logic ldPulse;
   logic [71:0] sum;
   teo_cmp_t qHead;
   logic qFire;
   logic qPush;
   logic sFire;
   logic duty;
   logic [64:0] stQ;
   logic [65:0] hs0;
   logic [65:0] hs1;

   // Byte-lane merge of a write into the old register value
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return r;
   endfunction

   // Compare of live time against an entry; seconds above bit 19 count
   function automatic logic reached(input logic [31:0] sec,
      input logic [31:0] ns, input teo_cmp_t c);
      return {sec, ns} >= {12'h000, c.sec, c.ns};
   endfunction

   // Requested trigger level; any other code toggles
   function automatic logic nextLvl(input logic cur, input logic [1:0] code);
      case (code)
         ST_LOW: nextLvl = 1'b0;
         ST_HIGH: nextLvl = 1'b1;
         default: nextLvl = ~cur;
      endcase
   endfunction

   // One step of a half-period countdown: {toggle, remaining time}.
   // The remainder carries over, so edge jitter never accumulates.
   function automatic logic [65:0] halfStep(input logic [64:0] rem,
      input logic [64:0] st, input logic [64:0] hp);
      logic signed [64:0] r;
      r = $signed(rem) - $signed(st);
      if (r <= 0) begin
         halfStep = {1'b1, 65'(r + $signed(hp))};
      end else begin
         halfStep = {1'b0, r};
      end
   endfunction

   // Register read decode: {mapped, data}
   function automatic logic [32:0] regRead(input logic [11:0] a,
      input teo_state_t st, input teo_cmp_t hd);
      case ({a[11:2], 2'b00})
         OFF_TCTRL: regRead = {1'b1, 32'h0000_0000};
         OFF_EVCTRL: regRead = {1'b1, st.evCtrl};
         OFF_STEPF: regRead = {1'b1, st.stepFrac};
         OFF_STEPW: regRead = {1'b1, st.stepWhole};
         OFF_SHNS: regRead = {1'b1, st.shNs};
         OFF_SHSEC: regRead = {1'b1, st.shSec};
         OFF_LIVENS: regRead = {1'b1, st.timeNs};
         OFF_LIVESEC: regRead = {1'b1, st.timeSec};
         OFF_CMPL: regRead = {1'b1, st.cmpLow};
         OFF_CMPH: regRead = {1'b1, 10'h000, hd.st, hd.sec};
         OFF_SCMPL: regRead = {1'b1, st.sCmpLow};
         OFF_SCMPH: regRead = {1'b1, 10'h000, st.single.st, st.single.sec};
         OFF_HP0L: regRead = {1'b1, st.hp0Low};
         OFF_HP0H: regRead = {1'b1, st.hp0[63:32]};
         OFF_HP1L: regRead = {1'b1, st.hp1Low};
         OFF_HP1H: regRead = {1'b1, st.hp1[63:32]};
         OFF_STATUS: regRead = {1'b1, 19'h0_0000, st.qCnt, 3'b000,
            st.sArmed, st.lvl1, st.lvl0, st.trigS, st.trigQ};
         OFF_RATE: regRead = {1'b1, CLK_HZ};
         default: regRead = {1'b0, 32'h0000_0000};
      endcase
   endfunction

   // Handshake outputs straight from state
   assign awready = !s.awHave;
   assign wready = !s.wHave;
   assign arready = !s.rValid;
   assign bvalid = s.bValid;
   assign bresp = s.bResp;
   assign rvalid = s.rValid;
   assign rdata = s.rData;
   assign rresp = s.rResp;

   // Pins; output enables gate the square wave levels to low, duty mode also the secondary
   assign queuedCompareOutput = s.trigQ;
   assign singleCompareOutput = s.trigS;
   assign primarySquareOutput = s.lvl0 & s.evCtrl[EV_P0OE];
   assign secondarySquareOutput = s.lvl1 & s.evCtrl[EV_P1OE] & !duty;

   // Next-state logic for bus, time base, triggers and square waves
   always_comb begin
      n = s;
      wa = {s.awAddr[11:2], 2'b00};
      wrDo = s.awHave && s.wHave && !s.bValid;
      qHead = s.queue[s.qRd];
      wrOld = regRead(s.awAddr, s, qHead);
      wd = merge(wrOld[31:0], s.wData, s.wStrb);
      rdVal = regRead(araddr, s, qHead);
      ldPulse = wrDo && (wa == OFF_TCTRL) && wd[TC_LOAD];
      duty = s.evCtrl[EV_DUTY];
      stQ = {25'h000_0000, s.stepLive[63:24]};

      // AXI4-Lite channels; address and data may come in either order
      if (awvalid && !s.awHave) begin
         n.awHave = 1'b1;
         n.awAddr = awaddr;
      end
      if (wvalid && !s.wHave) begin
         n.wHave = 1'b1;
         n.wData = wdata;
         n.wStrb = wstrb;
      end
      if (s.bValid && bready) begin
         n.bValid = 1'b0;
      end
      if (wrDo) begin
         n.awHave = 1'b0;
         n.wHave = 1'b0;
         n.bValid = 1'b1;
         n.bResp = wrOld[32] ? RESP_OKAY : RESP_SLVERR;
      end
      if (s.rValid && rready) begin
         n.rValid = 1'b0;
      end
      if (arvalid && !s.rValid) begin
         n.rValid = 1'b1;
         n.rData = rdVal[31:0];
         n.rResp = rdVal[32] ? RESP_OKAY : RESP_SLVERR;
      end

      // Adder clock; a zero increment leaves it standing
      sum = {s.timeNs, s.timeSub} + {8'h00, s.stepLive};
      n.timeSub = sum[39:0];
      if (sum[71:40] >= NS_PER_SEC) begin
         n.timeNs = sum[71:40] - NS_PER_SEC;
         n.timeSec = s.timeSec + 32'h0000_0001;
      end else begin
         n.timeNs = sum[71:40];
      end
      if (ldPulse) begin
         n.stepLive = {s.stepWhole, s.stepFrac};
         n.timeNs = s.shNs;
         n.timeSec = s.shSec;
         n.timeSub = 40'h00_0000_0000;
      end

      // Queued trigger: head compared, fired entry dropped
      qFire = s.evCtrl[EV_QTRIG] && (s.qCnt != 5'd0)
         && reached(s.timeSec, s.timeNs, qHead);
      qPush = wrDo && (wa == OFF_CMPH) && (s.qCnt < 5'(Q_DEPTH));
      if (qFire) begin
         n.trigQ = nextLvl(s.trigQ, qHead.st);
         n.qRd = s.qRd + 4'd1;
      end
      if (qPush) begin
         n.queue[s.qWr] = '{st: wd[21:20], sec: wd[19:0], ns: s.cmpLow};
         n.qWr = s.qWr + 4'd1;
      end
      n.qCnt = s.qCnt + {4'h0, qPush} - {4'h0, qFire};

      // Single trigger; a fresh write arms it even on the firing cycle
      sFire = s.evCtrl[EV_STRIG] && s.sArmed
         && reached(s.timeSec, s.timeNs, s.single);
      if (sFire) begin
         n.trigS = nextLvl(s.trigS, s.single.st);
         n.sArmed = 1'b0;
      end

      // Register writes; compare and half period values commit on the upper word
      if (wrDo) begin
         case (wa)
            OFF_EVCTRL: n.evCtrl = wd;
            OFF_STEPF: n.stepFrac = wd;
            OFF_STEPW: n.stepWhole = wd;
            OFF_SHNS: n.shNs = wd;
            OFF_SHSEC: n.shSec = wd;
            OFF_CMPL: n.cmpLow = wd;
            OFF_SCMPL: n.sCmpLow = wd;
            OFF_SCMPH: begin
               n.single = '{st: wd[21:20], sec: wd[19:0], ns: s.sCmpLow};
               n.sArmed = 1'b1;
            end
            OFF_HP0L: n.hp0Low = wd;
            OFF_HP0H: n.hp0 = {wd, s.hp0Low};
            OFF_HP1L: n.hp1Low = wd;
            OFF_HP1H: n.hp1 = {wd, s.hp1Low};
            default: begin
            end
         endcase
      end

      // Primary square output; duty mode alternates both pairs
      hs0 = halfStep(s.rem0, stQ,
         {1'b0, (duty && !s.phase0) ? s.hp1 : s.hp0});
      if (!s.evCtrl[EV_P0EN]) begin
         n.run0 = 1'b0;
         if (!s.evCtrl[EV_P0HOLD]) begin
            n.lvl0 = 1'b0;
         end
      end else if (!s.run0) begin
         n.run0 = 1'b1;
         n.lvl0 = s.evCtrl[EV_P0INIT];
         n.phase0 = 1'b0;
         n.rem0 = {1'b0, s.hp0};
      end else begin
         n.rem0 = hs0[64:0];
         if (hs0[65]) begin
            n.lvl0 = ~s.lvl0;
            n.phase0 = ~s.phase0;
         end
      end

      // Secondary square output, held off in duty mode
      hs1 = halfStep(s.rem1, stQ, {1'b0, s.hp1});
      if (!s.evCtrl[EV_P1EN] || duty) begin
         n.run1 = 1'b0;
         if (!s.evCtrl[EV_P1HOLD] || duty) begin
            n.lvl1 = 1'b0;
         end
      end else if (!s.run1) begin
         n.run1 = 1'b1;
         n.lvl1 = s.evCtrl[EV_P1INIT];
         n.rem1 = {1'b0, s.hp1};
      end else begin
         n.rem1 = hs1[64:0];
         if (hs1[65]) begin
            n.lvl1 = ~s.lvl1;
         end
      end
   end

   // State register
   always_ff @(posedge clk) begin
      if (!rstn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // All checks share the one clock; reset disables them
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   a_time_adds_step: assert property (
      !ldPulse |=> s.timeSub == $past(s.timeSub + s.stepLive[39:0]))
      else $error("time did not advance by the increment");
   a_time_zero_hold: assert property (
      (s.stepLive == 64'h0 && !ldPulse) |=> $stable(s.timeNs))
      else $error("time moved with zero increment");
   a_load_copies_all: assert property (
      ldPulse |=> (s.stepLive == $past({s.stepWhole, s.stepFrac}))
         && (s.timeSec == $past(s.shSec)) && (s.timeNs == $past(s.shNs)))
      else $error("shadow load incomplete");
   a_rate_read_value: assert property (
      (arvalid && arready && araddr == OFF_RATE) |=> rdata == CLK_HZ)
      else $error("rate register wrong");
   a_queue_depth_cap: assert property (s.qCnt <= 5'(Q_DEPTH))
      else $error("queue count above depth");
   a_fire_after_cmp: assert property (
      qFire |-> {s.timeSec, s.timeNs} >= {12'h000, qHead.sec, qHead.ns})
      else $error("queued trigger fired early");
   a_fire_high_lvl: assert property (
      (qFire && qHead.st == ST_HIGH) |=> queuedCompareOutput)
      else $error("high code did not drive high");
   a_fire_low_lvl: assert property (
      (qFire && qHead.st == ST_LOW) |=> !queuedCompareOutput)
      else $error("low code did not drive low");
   a_queue_pop_next: assert property (
      (qFire && !qPush) |=> (s.qCnt == $past(s.qCnt) - 5'd1)
         && (s.qRd == $past(s.qRd) + 4'd1))
      else $error("fired entry not dropped");
   a_start_init_lvl: assert property (
      (s.evCtrl[EV_P0EN] && !s.run0) |=> s.run0
         && (s.lvl0 == $past(s.evCtrl[EV_P0INIT]))
         && s.rem0 == $past({1'b0, s.hp0}))
      else $error("primary start level wrong");
   a_duty_blocks_sec: assert property (
      duty |=> !secondarySquareOutput)
      else $error("secondary output active in duty mode");
   a_half_split_load: assert property (
      (wrDo && wa == OFF_HP0H) |=> s.hp0 == $past({wd, s.hp0Low}))
      else $error("half period upper write did not commit");

   // Trigger enables, levels, the single entry, the increment word and the rate read
   a_queue_held_off: assert property (
      !s.evCtrl[EV_QTRIG] |=> s.trigQ == $past(s.trigQ))
      else $error("disabled queued trigger changed its pin");
   a_fire_not_late: assert property (
      (s.evCtrl[EV_QTRIG] && s.qCnt != 5'h00
         && {s.timeSec, s.timeNs} >= {12'h000, qHead.sec, qHead.ns})
         |-> qFire)
      else $error("queued trigger missed a reached compare time");
   a_toggle_code_flip: assert property (
      (qFire && qHead.st[1])
         |=> queuedCompareOutput != $past(queuedCompareOutput))
      else $error("toggle code did not invert the queued pin");
   a_single_high_lvl: assert property (
      (sFire && s.single.st == ST_HIGH) |=> singleCompareOutput)
      else $error("single high code did not drive high");
   a_single_one_shot: assert property (
      (sFire && !(wrDo && wa == OFF_SCMPH)) |=> !s.sArmed)
      else $error("single trigger still armed after firing");
   a_step_word_load: assert property (
      (wrDo && wa == OFF_STEPW) |=> s.stepWhole == $past(wd))
      else $error("increment whole word not stored");
   a_rate_read_okay: assert property (
      (arvalid && arready && araddr == OFF_RATE) |=> rresp == RESP_OKAY)
      else $error("rate register read not answered okay");

   // Square output start, stop and half period bookkeeping
   a_stop_forces_low: assert property (
      (!s.evCtrl[EV_P0EN] && !s.evCtrl[EV_P0HOLD]) |=> !s.lvl0)
      else $error("stopped primary output not forced low");
   a_start_level_high: assert property (
      (s.evCtrl[EV_P0EN] && s.evCtrl[EV_P0OE] && s.evCtrl[EV_P0INIT]
         && !s.run0) |=> primarySquareOutput)
      else $error("primary output did not start high");
   a_half_edge_flip: assert property (
      (s.evCtrl[EV_P0EN] && s.run0 && hs0[65]) |=> s.lvl0 != $past(s.lvl0))
      else $error("primary output did not invert after half period");
   a_remainder_carry: assert property (
      (s.evCtrl[EV_P0EN] && s.run0 && !duty && hs0[65])
         |=> s.rem0 == $past(s.rem0 - stQ + {1'b0, s.hp0}))
      else $error("half period remainder not carried");
   a_countdown_step: assert property (
      (s.evCtrl[EV_P0EN] && s.run0 && !hs0[65])
         |=> s.rem0 == $past(s.rem0 - stQ))
      else $error("half period countdown did not step by the increment");

endmodule
`default_nettype wire

/* File: dv/teo_pin_monitor.sv */
// Receiver model for the four event pins: counts edges on each pin.
// Assumes pins change only at rising clock edges.
`timescale 1ns/1ps
`default_nettype none
module teo_pin_monitor (
   input wire logic clk,
   input wire logic [3:0] pins,
   output logic [3:0][7:0] rises,
   output logic [3:0][7:0] falls,
   output logic [31:0] lastEdge,
   output logic [31:0] prevEdge
);
   logic [3:0] seen_ff;
   logic [31:0] cyc_ff;

   // Start with no edges seen and all four pins taken as low
   initial begin
      rises = '0;
      falls = '0;
      lastEdge = '0;
      prevEdge = '0;
      seen_ff = '0;
      cyc_ff = '0;
   end

   // Sampled mid-cycle so the pin update at the rising edge never races
   always @(negedge clk) begin
      cyc_ff <= cyc_ff + 32'h0000_0001;
      seen_ff <= pins;
      for (int i = 0; i < 4; i++) begin
         if (pins[i] && !seen_ff[i]) begin
            rises[i] <= rises[i] + 8'h01;
         end
         if (!pins[i] && seen_ff[i]) begin
            falls[i] <= falls[i] + 8'h01;
         end
      end
      // Edge times of the primary square pin, for half period checks
      if (pins[2] != seen_ff[2]) begin
         prevEdge <= lastEdge;
         lastEdge <= cyc_ff;
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb.sv */
// Self-checking bench of the timed event output unit over AXI4-Lite.
// Assumes the edge counting pin model sits on the four event pins.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
   $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb import teo_pkg::*;;
   logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, rv;
   logic [3:0] wstrb;
   wire logic [3:0] pins;
   logic [1:0] bresp, rresp, lastResp;
   logic [3:0][7:0] rises, falls;
   logic [31:0] lastEdge, prevEdge;
   int failures, checks;

   teo_timed_event_outputs teo_timed_event_outputs_i (.clk(clk), .rstn(rstn),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
      .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
      .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready), .queuedCompareOutput(pins[0]),
      .singleCompareOutput(pins[1]), .primarySquareOutput(pins[2]),
      .secondarySquareOutput(pins[3]));
   teo_pin_monitor teo_pin_monitor_i (.clk(clk), .pins(pins), .rises(rises),
      .falls(falls), .lastEdge(lastEdge), .prevEdge(prevEdge));

   // 125 MHz clock
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic tally_and_finish;
      if (failures == 0 && checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // Ready and valid are sampled mid-cycle, so a handshake seen there is
   // the one taken at the next rising edge
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic pa, pw, sa, sw, sb;
      pa = 1'b1;
      pw = 1'b1;
      sb = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 40 && !sb; n++) begin
         @(negedge clk);
         sa = awready;
         sw = wready;
         sb = bvalid;
         lastResp = bresp;
         @(posedge clk);
         if (pa && sa) begin
            pa = 1'b0;
            awvalid <= 1'b0;
         end
         if (pw && sw) begin
            pw = 1'b0;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b0;
      `CHK("write response", 1'b1, sb)
   endtask

   task automatic rd(input logic [11:0] a);
      logic pa, sa, sr;
      pa = 1'b1;
      sr = 1'b0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 40 && !sr; n++) begin
         @(negedge clk);
         sa = arready;
         sr = rvalid;
         rv = rdata;
         lastResp = rresp;
         @(posedge clk);
         if (pa && sa) begin
            pa = 1'b0;
            arvalid <= 1'b0;
         end
      end
      rready <= 1'b0;
      `CHK("read response", 1'b1, sr)
   endtask

   // Bounded wait until a pin has made the given number of edges
   task automatic waitEdges(input int idx, input int total);
      int n;
      n = 0;
      while (int'(rises[idx]) + int'(falls[idx]) < total && n < 600) begin
         @(negedge clk);
         n++;
      end
      `CHK("pin edge count", 1'b1, n < 600)
   endtask

   function automatic logic gapIn(input logic [31:0] lo,
      input logic [31:0] hi);
      return (lastEdge - prevEdge) >= lo && (lastEdge - prevEdge) <= hi;
   endfunction

   task automatic t_regs;
      rd(OFF_RATE);
      `CHK("clock rate", CLK_RATE_HZ, rv)
      rd(12'hFFC);
      `CHK("unmapped read", RESP_SLVERR, lastResp)
      wr(12'hFFC, 32'h0000_0001);
      `CHK("unmapped write", RESP_SLVERR, lastResp)
   endtask

   // Step 8 ns and time 12 s 10 ns, copied to the live clock in one go
   task automatic t_load;
      wr(OFF_STEPF, 32'h0000_0000);
      wr(OFF_STEPW, 32'h0000_0800);
      wr(OFF_SHNS, 32'h0000_000A);
      wr(OFF_SHSEC, 32'h0000_000C);
      rd(OFF_LIVENS);
      `CHK("time before load", 32'h0000_0000, rv)
      wr(OFF_TCTRL, 32'h0000_0001);
      rd(OFF_LIVESEC);
      `CHK("seconds loaded", 32'h0000_000C, rv)
      rd(OFF_LIVENS);
      `CHK("ns on step grid", 3'h2, rv[2:0])
      `CHK("time running", 1'b1, rv > 32'h0000_000A)
   endtask

   // Entries high, low, toggle, high: the last must not make an edge
   task automatic t_queue;
      logic [1:0] cd [4];
      cd = '{2'b01, 2'b00, 2'b10, 2'b01};
      wr(OFF_EVCTRL, 32'h0000_0004);
      for (int i = 0; i < 4; i++) begin
         wr(OFF_CMPL, 32'h0000_07D0 + 32'(i) * 32'h0000_0190);
         wr(OFF_CMPH, {10'h000, cd[i], 20'h0_000C});
      end
      `CHK("queued early", 1'b0, pins[0])
      waitEdges(0, 1);
      rd(OFF_LIVENS);
      `CHK("queued not early", 1'b1, rv >= 32'h0000_07D0)
      `CHK("queued lag", 1'b1, rv < 32'h0000_0810)
      for (int n = 0; n < 200 && rv < 32'h0000_0D00; n++) begin
         rd(OFF_LIVENS);
      end
      `CHK("queued rises", 8'h02, rises[0])
      `CHK("queued falls", 8'h01, falls[0])
      `CHK("queued level", 1'b1, pins[0])
      rd(OFF_STATUS);
      `CHK("queue drained", 5'h00, rv[12:8])
   endtask

   // Disabled queue holds entries; the seventeenth write is dropped
   task automatic t_full;
      wr(OFF_EVCTRL, 32'h0000_0000);
      wr(OFF_CMPL, 32'h0000_0010);
      rd(OFF_STATUS);
      `CHK("low word alone", 5'h00, rv[12:8])
      for (int i = 0; i < 17; i++) begin
         wr(OFF_CMPH, 32'h0010_0064);
      end
      rd(OFF_STATUS);
      `CHK("queue full", 5'h10, rv[12:8])
      `CHK("disabled holds", 8'h02, rises[0])
   endtask

   task automatic t_single;
      logic [31:0] t;
      wr(OFF_EVCTRL, 32'h0000_0008);
      rd(OFF_LIVENS);
      t = rv + 32'h0000_0320;
      wr(OFF_SCMPL, t);
      wr(OFF_SCMPH, 32'h0010_000C);
      `CHK("single early", 1'b0, pins[1])
      waitEdges(1, 1);
      rd(OFF_LIVENS);
      `CHK("single not early", 1'b1, rv >= t)
      `CHK("single lag", 1'b1, rv < t + 32'h0000_0040)
      `CHK("queued untouched", 1'b1, pins[0])
   endtask

   // Half period 100 ns is 12.5 cycles: gaps of 12 or 13, no drift
   task automatic t_period;
      logic [31:0] e0;
      `CHK("primary idle", 1'b0, pins[2])
      wr(OFF_HP0L, 32'h0064_0000);
      wr(OFF_HP0H, 32'h0000_0000);
      wr(OFF_EVCTRL, 32'h0000_0150);
      @(negedge clk);
      `CHK("start level", 1'b1, pins[2])
      waitEdges(2, 2);
      e0 = lastEdge;
      `CHK("first half", 1'b1, gapIn(32'h0000_000C, 32'h0000_000D))
      waitEdges(2, 10);
      `CHK("half period", 1'b1, gapIn(32'h0000_000C, 32'h0000_000D))
      `CHK("no drift", 1'b1, lastEdge - e0 >= 32'h0000_0063 &&
         lastEdge - e0 <= 32'h0000_0065)
      wr(OFF_EVCTRL, 32'h0000_0140);
      wr(OFF_EVCTRL, 32'h0000_0040);
      @(negedge clk);
      `CHK("stopped low", 1'b0, pins[2])
   endtask

   // Duty mode: high 100 ns from pair 0, low 50 ns from pair 1
   task automatic t_duty;
      int b;
      b = int'(rises[2]) + int'(falls[2]);
      wr(OFF_HP1L, 32'h0032_0000);
      wr(OFF_HP1H, 32'h0000_0000);
      wr(OFF_EVCTRL, 32'h0000_11F0);
      waitEdges(2, b + 2);
      `CHK("duty high", 1'b1, gapIn(32'h0000_000C, 32'h0000_000D))
      waitEdges(2, b + 3);
      `CHK("duty low", 1'b1, gapIn(32'h0000_0006, 32'h0000_0007))
      `CHK("secondary off", 8'h00, rises[3])
      wr(OFF_EVCTRL, 32'h0000_00A0);
      waitEdges(3, 2);
      `CHK("secondary wave", 8'h01, rises[3])
   endtask

   // Main sequence: reset for 4 cycles, then each scenario in turn
   initial begin
      rstn = 1'b0;
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      failures = 0;
      checks = 0;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      t_regs;
      t_load;
      t_queue;
      t_full;
      t_single;
      t_period;
      t_duty;
      tally_and_finish;
   end

   // Whole run needs about a thousand cycles; this cuts a hang short
   initial begin
      repeat (30000) @(posedge clk);
      failures++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
